// File: test/pmbus_host_model.sv
// Host side model of the command port: single write and read accesses.
// Assumes the sequencer takes a command on a rising clk_sys edge with cmd_valid high.
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        clk_sys,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic [15:0] cmd_rdata
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Time words carry a 5-bit exponent above an 11-bit mantissa.
  function automatic logic [15:0] lin11(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction

  // Code and data lines are inverted after the strobe so a stale code never looks valid.
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code  = code;
    cmd_wdata = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~d;
    @(negedge clk_sys);
    q = cmd_rdata;
  endtask
endmodule // pmbus_host_model

// File: test/test_power_seq_monitor.sv
// Self-checking bench of the power sequencer with a host model on the command port.
// Assumes a 1 ms tick of 10 clocks; phase waits below scale with MS, except the raw 15- and 25-clock waits in s_stop.
`timescale 1ns/1ps
`include "power_seq_map.svh"
module test_power_seq_monitor;
  localparam int MS = 10;
  logic        clk_sys, rst, cmd_valid, cmd_write, ctrl_en, op_en, pwr_ok, droop, act_share;
  logic        output_enable, rise_active, fall_active, pg_pin, alert_n;
  logic [4:0]  flt;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vout;
  int          err_count, n_compared, cyc;

  power_seq_monitor #(.MS_CYCLES(MS)) power_seq_monitor_inst (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .ctrl_pin_enable(ctrl_en), .operation_enable(op_en), .input_power_ok(pwr_ok),
    .vin_uv_fault(flt[2]), .vout_ov_fault(flt[4]), .iout_oc_fault(flt[3]),
    .temp_fault(flt[1]), .cml_fault(flt[0]), .droop_load_sharing(droop),
    .active_current_sharing(act_share), .vout_level(vout), .output_enable(output_enable),
    .rise_active(rise_active), .fall_active(fall_active),
    .power_good_sync_pin(pg_pin), .fault_alert_pin_n(alert_n)
  );

  pmbus_host_model pmbus_host_model_inst (
    .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The ceiling is well above the roughly 4000 cycles the scenarios need.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      finish_test;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Selects 0 enable, 1 rise, 2 fall, 3 power good, 4 alert.
  function automatic logic [15:0] sig(input int sel);
    logic [4:0] v;
    v = {alert_n, pg_pin, fall_active, rise_active, output_enable};
    return {15'h0000, v[sel]};
  endfunction

  // Phases run on a free tick, so a change lands between ms-1 and ms after the cause.
  task automatic wait_for(input int sel, input logic v, input int ms);
    int n;
    repeat (ms * MS - MS - 3) @(negedge clk_sys);
    check(sig(sel), {15'h0000, ~v});
    n = 0;
    while (sig(sel) !== {15'h0000, v} && n < MS + 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(sig(sel), {15'h0000, v});
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    logic [15:0] q;
    pmbus_host_model_inst.access(1'b1, code, d, q);
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] q;
    pmbus_host_model_inst.access(1'b0, code, 16'h0000, q);
    check(q, exp);
  endtask

  task automatic s_regs;
    logic [7:0] codes [10];
    codes = '{`CMD_UV_RESP, `CMD_PG_ON, `CMD_PG_OFF, `CMD_ON_DELAY, `CMD_ON_RISE,
              `CMD_TON_MAX, `CMD_OFF_DELAY, `CMD_OFF_FALL, `CMD_TOFF_WARN, 8'h63};
    for (int i = 0; i < 10; i++) wr(codes[i], {codes[i], ~codes[i]});
    rd(codes[0], {8'h00, ~codes[0]});
    for (int i = 1; i < 9; i++) rd(codes[i], {codes[i], ~codes[i]});
    rd(8'h63, 16'h0000);
    wr(`CMD_STATUS_BYTE, 16'hFFFF);
    rd(`CMD_STATUS_BYTE, 16'h0000);
    for (int j = 0; j < 5; j++)
    begin
      flt = 5'h01 << j;
      rd(`CMD_STATUS_BYTE, {10'h000, flt, 1'b0});
      rd(`CMD_STATUS_WORD, {flt[4:2], 7'h00, flt, 1'b0});
    end
    flt = 5'h00;
    $display("done s_regs");
  endtask

  task automatic s_start;
    wr(`CMD_ON_DELAY, pmbus_host_model_inst.lin11(5'h01, 11'h001));
    wr(`CMD_ON_RISE, 16'h0005);
    wr(`CMD_TON_MAX, 16'h0000);
    wr(`CMD_OFF_DELAY, 16'h0003);
    wr(`CMD_OFF_FALL, 16'h000C);
    wr(`CMD_TOFF_WARN, 16'h0000);
    wr(`CMD_PG_ON, 16'h0100);
    wr(`CMD_PG_OFF, 16'h0080);
    wr(`CMD_UV_RESP, 16'h0000);
    ctrl_en = 1'b1;
    wait_for(0, 1'b1, 41);
    check(sig(1), 16'h0001);
    check(sig(3), 16'h0001);
    wait_for(1, 1'b0, 10);
    repeat (15 * MS) @(negedge clk_sys);
    check(sig(4), 16'h0001);
    vout = 16'h0200;
    repeat (3) @(negedge clk_sys);
    check(sig(3), 16'h0000);
    $display("done s_start");
  endtask

  task automatic s_stop;
    op_en = 1'b0;
    repeat (15) @(negedge clk_sys);
    check(sig(0), 16'h0001);
    repeat (25) @(negedge clk_sys);
    check(sig(0), 16'h0000);
    check(sig(2), 16'h0001);
    repeat (9 * MS) @(negedge clk_sys);
    check(sig(2), 16'h0001);
    check(sig(4), 16'h0001);
    repeat (25) @(negedge clk_sys);
    check(sig(2), 16'h0000);
    check(sig(4), 16'h0001);
    repeat (25) @(negedge clk_sys);
    check(sig(4), 16'h0000);
    vout = 16'h0010;
    repeat (3) @(negedge clk_sys);
    check(sig(3), 16'h0001);
    check(sig(4), 16'h0000);
    $display("done s_stop");
  endtask

  task automatic s_fault;
    op_en = 1'b1;
    wait_for(0, 1'b1, 2);
    check(sig(4), 16'h0001);
    vout = 16'h0200;
    wait_for(1, 1'b0, 10);
    wr(`CMD_UV_RESP, 16'h0040);
    flt[2] = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(sig(0), 16'h0001);
    wr(`CMD_UV_RESP, 16'h00C0);
    repeat (3) @(negedge clk_sys);
    check(sig(0), 16'h0000);
    check(sig(4), 16'h0000);
    flt[2] = 1'b0;
    repeat (5 * MS) @(negedge clk_sys);
    check(sig(0), 16'h0000);
    vout = 16'h0000;
    wr(`CMD_TON_MAX, 16'h0001);
    ctrl_en = 1'b0;
    @(negedge clk_sys);
    ctrl_en = 1'b1;
    wait_for(0, 1'b1, 2);
    check(sig(4), 16'h0001);
    wait_for(4, 1'b0, 20);
    check(sig(0), 16'h0000);
    rd(`CMD_STATUS_WORD, 16'h8000);
    $display("done s_fault");
  endtask

  task automatic s_share;
    droop = 1'b1;
    wr(`CMD_ON_RISE, 16'h0005);
    wr(`CMD_TON_MAX, 16'h0000);
    vout = 16'h0200;
    pwr_ok = 1'b0;
    @(negedge clk_sys);
    pwr_ok = 1'b1;
    wait_for(0, 1'b1, 41);
    check(sig(4), 16'h0001);
    // Swapping the sharing mode mid-rise must not shorten the fixed rise time.
    repeat (100 * MS) @(negedge clk_sys);
    droop = 1'b0;
    act_share = 1'b1;
    wait_for(1, 1'b0, 100);
    $display("done s_share");
  endtask

  initial
  begin
    rst = 1'b1;
    ctrl_en = 1'b0;
    op_en = 1'b1;
    pwr_ok = 1'b1;
    droop = 1'b0;
    act_share = 1'b0;
    flt = 5'h00;
    vout = 16'h0000;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    s_regs;
    s_start;
    s_stop;
    s_fault;
    s_share;
    finish_test;
  end
endmodule // test_power_seq_monitor

// File: verilog/linear11_to_ms.sv
// Converts an exponent/mantissa time word to whole milliseconds.
// Assumes the word holds a non-negative time; negative mantissas read as zero.
`timescale 1ns/1ps
module linear11_to_ms (
  input  wire logic [15:0] word,
  output logic      [15:0] ms
);
  logic signed [4:0] expo;
  logic        [10:0] man;
  logic        [31:0] wide;

  always_comb
  begin
    expo = word[15:11];
    man  = word[10:0];
    wide = 32'h0000_0000;
    if (man[10])
    begin
      ms = 16'h0000;
    end
    else
    begin
      if (expo[4])
        wide = {21'h00_0000, man} >> 5'(-expo); // R17
      else
        wide = {21'h00_0000, man} << 5'(expo); // R17
      // Large products saturate rather than wrap to a short time.
      ms = (|wide[31:16]) ? 16'hFFFF : wide[15:0];
    end
  end
endmodule // linear11_to_ms

// File: verilog/ms_tick_gen.sv
// Divides the system clock down to a one-cycle pulse per millisecond.
// Assumes CYCLES is at least 1.
`timescale 1ns/1ps
module ms_tick_gen
  import power_seq_pkg::*;
#(
  parameter int unsigned CYCLES = 10000
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick
);
  tick_regs_t q;
  tick_regs_t d;

  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= CYCLES - 1)
    begin
      d.cnt  = 32'h0000_0000;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;
endmodule // ms_tick_gen

// File: verilog/power_seq_map.svh
// Command codes, field positions, reset values and timing figures of the power sequencer.
// Assumes one 10 MHz system clock; times are kept in milliseconds.
`ifndef POWER_SEQ_MAP_SVH
`define POWER_SEQ_MAP_SVH
`define CMD_UV_RESP      8'h5A
`define CMD_PG_ON        8'h5E
`define CMD_PG_OFF       8'h5F
`define CMD_ON_DELAY     8'h60
`define CMD_ON_RISE      8'h61
`define CMD_TON_MAX      8'h62
`define CMD_OFF_DELAY    8'h64
`define CMD_OFF_FALL     8'h65
`define CMD_TOFF_WARN    8'h66
`define CMD_STATUS_BYTE  8'h78
`define CMD_STATUS_WORD  8'h79
`define SLOT_ON_DELAY    0
`define SLOT_ON_RISE     1
`define SLOT_TON_MAX     2
`define SLOT_OFF_DELAY   3
`define SLOT_OFF_FALL    4
`define SLOT_TOFF_WARN   5
`define UV_RESP_MSB      7
`define UV_RESP_LSB      6
`define UV_RESP_TURN_OFF 2'h3
`define ST_VOUT_OV       5
`define ST_IOUT_OC       4
`define ST_VIN_UV        3
`define ST_TEMP          2
`define ST_CML           1
`define SW_VOUT          15
`define SW_IOUT          14
`define SW_VIN           13
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define CLK_PERIOD_NS    100
`define MS_NS            1000000
`define ON_DELAY_MIN_MS  18'h00001
`define POR_EXTRA_MS     18'h00027
`define RISE_MIN_MS      18'h0000A
`define RISE_SHARE_MS    18'h000C8
`define FALL_MIN_MS      18'h0000A
`define WARN_MARGIN_MS   18'h00005
`endif

// File: verilog/power_seq_monitor.sv
// Output power sequencing, start and stop supervision and summary status.
// Assumes all inputs are synchronous to clk_sys and the command port is fed by a host bridge.
//
// Function
// R1 - Response field 11 in bits 7:6 turns output off on input under-voltage.
// R2 - Latched fault clears on control pin, operation enable or input power restart.
// R3 - Output above assert level drives power-good pin low; also the start target.
// R4 - Output below deassert level drives power-good pin high.
// R5 - Power-good pin stays high throughout start-up.
// R6 - Wait programmed turn-on delay before rise, never under 1 ms.
// R7 - After input power restart add fixed 39 ms to turn-on delay.
// R8 - Rise time at least 10 ms, or 200 ms with current sharing.
// R9 - Rise time writes are ignored while current sharing is on; the code still stores them, and they apply once sharing ends.
// R10 - Missing the assert level within start limit latches fault, alert held low.
// R11 - Start limit of zero disables start-up timeout checking.
// R12 - Start limit floor is rise plus 10 ms, or plus 200 ms sharing.
// R13 - After disable wait programmed turn-off delay before the fall.
// R14 - Fall lasts programmed fall time, at least 10 ms.
// R15 - Fall warning limit at least fall plus 5 ms; overrun holds alert low.
// R16 - Status byte bits report faults: 5 OV, 4 OC, 3 UV, 2 OT, 1 CML.
// R17 - Time words decode as signed 5-bit exponent and signed 11-bit mantissa; the code reads negative mantissas as zero.
`timescale 1ns/1ps
`include "power_seq_map.svh"
module power_seq_monitor
  import power_seq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  input  wire logic        ctrl_pin_enable,
  input  wire logic        operation_enable,
  input  wire logic        input_power_ok,
  input  wire logic        vin_uv_fault,
  input  wire logic        vout_ov_fault,
  input  wire logic        iout_oc_fault,
  input  wire logic        temp_fault,
  input  wire logic        cml_fault,
  input  wire logic        droop_load_sharing,
  input  wire logic        active_current_sharing,
  input  wire logic [15:0] vout_level,
  output logic             output_enable,
  output logic             rise_active,
  output logic             fall_active,
  output logic             power_good_sync_pin,
  output logic             fault_alert_pin_n
);
  seq_regs_t        q;
  seq_regs_t        d;
  logic             tick;
  logic [5:0][15:0] ms;
  logic             shr;
  logic             en;
  logic             clr;
  logic             vabove;
  logic             vbelow;
  logic [17:0]      dly_ms;
  logic [17:0]      rise_ms;
  logic [17:0]      ton_lim;
  logic [17:0]      toffd_ms;
  logic [17:0]      fall_ms;
  logic [17:0]      warn_lim;
  logic             uv_trip;
  logic             ton_trip;
  logic             toff_trip;

  function automatic logic [17:0] max18(input logic [17:0] a, input logic [17:0] b);
    return (a > b) ? a : b;
  endfunction

  ms_tick_gen #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick)
  );

  for (genvar i = 0; i < 6; i++)
  begin : g_dec
    linear11_to_ms u_dec (
      .word (q.tim[i]),
      .ms   (ms[i])
    );
  end

  assign shr      = droop_load_sharing | active_current_sharing;
  assign en       = ctrl_pin_enable & operation_enable & input_power_ok;
  // Any re-enable edge or return of input power counts as a clear request.
  assign clr      = (ctrl_pin_enable & ~q.ctrl_prev) | (operation_enable & ~q.op_prev)
                  | (input_power_ok & ~q.vin_prev); // R2
  assign vabove   = vout_level > q.pg_on_lvl; // R3
  assign vbelow   = vout_level < q.pg_off_lvl; // R4
  assign dly_ms   = max18({2'b00, ms[`SLOT_ON_DELAY]}, `ON_DELAY_MIN_MS) // R6
                  + (q.por_pend ? `POR_EXTRA_MS : 18'h00000); // R7
  // Sharing forces the fixed rise time, so stored rise writes have no effect then.
  assign rise_ms  = shr ? `RISE_SHARE_MS // R9
                  : max18({2'b00, ms[`SLOT_ON_RISE]}, `RISE_MIN_MS); // R8
  assign ton_lim  = max18({2'b00, ms[`SLOT_TON_MAX]},
                          rise_ms + (shr ? `RISE_SHARE_MS : `RISE_MIN_MS)); // R12
  assign toffd_ms = {2'b00, ms[`SLOT_OFF_DELAY]};
  assign fall_ms  = max18({2'b00, ms[`SLOT_OFF_FALL]}, `FALL_MIN_MS); // R14
  assign warn_lim = max18({2'b00, ms[`SLOT_TOFF_WARN]}, fall_ms + `WARN_MARGIN_MS); // R15
  assign uv_trip  = vin_uv_fault
                  && (q.uv_resp[`UV_RESP_MSB:`UV_RESP_LSB] == `UV_RESP_TURN_OFF); // R1
  assign ton_trip = q.on_run && !vabove && (q.tim[`SLOT_TON_MAX] != 16'h0000) // R11
                  && (q.on_cnt >= ton_lim); // R10
  assign toff_trip = q.off_run && !vbelow && (q.off_cnt >= warn_lim); // R15

  always_comb
  begin
    d           = q;
    d.ctrl_prev = ctrl_pin_enable;
    d.op_prev   = operation_enable;
    d.vin_prev  = input_power_ok;
    // A fault arriving in the clearing cycle survives the clear.
    d.latched   = (q.latched & ~clr) | uv_trip | ton_trip; // R2
    d.ton_flt   = (q.ton_flt & ~clr) | ton_trip; // R10
    d.toff_wrn  = (q.toff_wrn & ~clr) | toff_trip; // R15

    if (q.on_run)
    begin
      if (vabove || ton_trip)
        d.on_run = 1'b0; // R3
      else if (tick)
        d.on_cnt = q.on_cnt + 18'h00001;
    end
    if (q.off_run)
    begin
      if (vbelow || toff_trip)
        d.off_run = 1'b0;
      else if (tick)
        d.off_cnt = q.off_cnt + 18'h00001;
    end

    case (q.st)
      S_OFF:
      begin
        if (en && !q.latched)
        begin
          d.st = S_TON_DLY;
          d.ph = 18'h00000;
        end
      end
      S_TON_DLY:
      begin
        if (!en)
          d.st = S_OFF;
        else if (q.ph >= dly_ms) // R6
        begin
          d.st       = S_RISE;
          d.ph       = 18'h00000;
          d.out_en   = 1'b1;
          d.rise     = 1'b1;
          d.on_run   = 1'b1;
          d.on_cnt   = 18'h00000;
          d.por_pend = 1'b0;
        end
        else if (tick)
          d.ph = q.ph + 18'h00001;
      end
      S_RISE, S_ON:
      begin
        if (!en)
        begin
          d.st      = S_TOFF_DLY;
          d.ph      = 18'h00000;
          d.rise    = 1'b0;
          // Start supervision ends once the output is being turned off.
          d.on_run  = 1'b0;
          d.off_run = 1'b1;
          d.off_cnt = 18'h00000;
        end
        else if (q.st == S_RISE)
        begin
          if (q.ph >= rise_ms) // R8
          begin
            d.st   = S_ON;
            d.rise = 1'b0;
          end
          else if (tick)
            d.ph = q.ph + 18'h00001;
        end
      end
      S_TOFF_DLY:
      begin
        if (q.ph >= toffd_ms) // R13
        begin
          d.st     = S_FALL;
          d.ph     = 18'h00000;
          d.out_en = 1'b0;
          d.fall   = 1'b1;
        end
        else if (tick)
          d.ph = q.ph + 18'h00001;
      end
      S_FALL:
      begin
        if (q.ph >= fall_ms) // R14
        begin
          d.st   = S_OFF;
          d.fall = 1'b0;
        end
        else if (tick)
          d.ph = q.ph + 18'h00001;
      end
      default:
        d.st = S_OFF;
    endcase

    // Protection shutdown drops the output at once, without the soft fall.
    if (uv_trip || ton_trip)
    begin
      d.st     = S_OFF; // R1
      d.out_en = 1'b0;
      d.rise   = 1'b0;
      d.fall   = 1'b0;
      d.on_run = 1'b0;
    end
    // Set after the state case so a restart during sequencing is not lost.
    if (input_power_ok && !q.vin_prev)
      d.por_pend = 1'b1; // R7

    if (d.st == S_TON_DLY || d.st == S_RISE)
      d.pg = 1'b1; // R5
    else if (vabove)
      d.pg = 1'b0; // R3
    else if (vbelow)
      d.pg = 1'b1; // R4
    d.alert_n = ~(d.latched | d.toff_wrn); // R10

    d.status              = `RST_BYTE;
    d.status[`ST_VOUT_OV] = vout_ov_fault; // R16
    d.status[`ST_IOUT_OC] = iout_oc_fault; // R16
    d.status[`ST_VIN_UV]  = vin_uv_fault; // R16
    d.status[`ST_TEMP]    = temp_fault; // R16
    d.status[`ST_CML]     = cml_fault; // R16

    if (cmd_valid && cmd_write)
    begin
      case (cmd_code)
        `CMD_UV_RESP:    d.uv_resp = cmd_wdata[7:0];
        `CMD_PG_ON:      d.pg_on_lvl = cmd_wdata;
        `CMD_PG_OFF:     d.pg_off_lvl = cmd_wdata;
        `CMD_ON_DELAY:   d.tim[`SLOT_ON_DELAY] = cmd_wdata;
        `CMD_ON_RISE:    d.tim[`SLOT_ON_RISE] = cmd_wdata;
        `CMD_TON_MAX:    d.tim[`SLOT_TON_MAX] = cmd_wdata;
        `CMD_OFF_DELAY:  d.tim[`SLOT_OFF_DELAY] = cmd_wdata;
        `CMD_OFF_FALL:   d.tim[`SLOT_OFF_FALL] = cmd_wdata;
        `CMD_TOFF_WARN:  d.tim[`SLOT_TOFF_WARN] = cmd_wdata;
        default:         d.uv_resp = q.uv_resp;
      endcase
    end
    else if (cmd_valid)
    begin
      case (cmd_code)
        `CMD_UV_RESP:     d.rdata = {8'h00, q.uv_resp};
        `CMD_PG_ON:       d.rdata = q.pg_on_lvl;
        `CMD_PG_OFF:      d.rdata = q.pg_off_lvl;
        `CMD_ON_DELAY:    d.rdata = q.tim[`SLOT_ON_DELAY];
        `CMD_ON_RISE:     d.rdata = q.tim[`SLOT_ON_RISE];
        `CMD_TON_MAX:     d.rdata = q.tim[`SLOT_TON_MAX];
        `CMD_OFF_DELAY:   d.rdata = q.tim[`SLOT_OFF_DELAY];
        `CMD_OFF_FALL:    d.rdata = q.tim[`SLOT_OFF_FALL];
        `CMD_TOFF_WARN:   d.rdata = q.tim[`SLOT_TOFF_WARN];
        `CMD_STATUS_BYTE: d.rdata = {8'h00, q.status};
        `CMD_STATUS_WORD:
        begin
          d.rdata           = {8'h00, q.status};
          d.rdata[`SW_VOUT] = q.status[`ST_VOUT_OV] | q.ton_flt | q.toff_wrn;
          d.rdata[`SW_IOUT] = q.status[`ST_IOUT_OC];
          d.rdata[`SW_VIN]  = q.status[`ST_VIN_UV];
        end
        default:          d.rdata = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q         <= '0;
      q.st      <= S_OFF;
      q.pg      <= 1'b1;
      q.alert_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign cmd_rdata           = q.rdata;
  assign output_enable       = q.out_en;
  assign rise_active         = q.rise;
  assign fall_active         = q.fall;
  assign power_good_sync_pin = q.pg;
  assign fault_alert_pin_n   = q.alert_n;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence uv_trip_s;
    vin_uv_fault && q.uv_resp[7:6] == 2'b11;
  endsequence
  sequence output_dead_s;
    !output_enable && q.st == S_OFF;
  endsequence

  uv_shutdown_a: assert property (uv_trip_s |=> output_dead_s) // R1
    else $error("under-voltage turn-off did not stop the output");
  fault_clear_a: assert property (q.latched && !uv_trip && !ton_trip // R2
                                  && ($rose(ctrl_pin_enable) || $rose(operation_enable)
                                  || $rose(input_power_ok)) |=> !q.latched)
    else $error("latched fault survived an enable edge");
  pg_assert_a: assert property (q.st == S_ON && en && vabove |=> !power_good_sync_pin) // R3
    else $error("power good not driven low above assert level");
  pg_deassert_a: assert property (q.st == S_OFF && vbelow && !vabove // R4
                                  |=> power_good_sync_pin)
    else $error("power good not driven high below deassert level");
  startup_pg_a: assert property (q.st == S_RISE |-> power_good_sync_pin) // R5
    else $error("power good low during start-up");
  ton_min_a: assert property (q.st == S_TON_DLY && q.ph == 18'h00000 // R6
                              |=> q.st != S_RISE)
    else $error("rise started before one millisecond");
  por_delay_a: assert property (q.st == S_TON_DLY && q.por_pend && q.ph < 18'h00027 // R7
                                |=> q.st != S_RISE)
    else $error("power restart delay shorter than 39 ms");
  rise_min_a: assert property (q.st == S_RISE && q.ph < (shr ? 18'h000C8 : 18'h0000A) // R8
                               |=> q.st != S_ON)
    else $error("rise time below minimum");
  ton_fault_a: assert property ($rose(q.ton_flt) |-> !fault_alert_pin_n [*2]) // R10
    else $error("start timeout did not hold the alert low");
  ton_off_a: assert property (q.tim[2] == 16'h0000 && !q.ton_flt |=> !q.ton_flt) // R11
    else $error("start timeout fired while disabled");
  toff_delay_a: assert property (q.st == S_TOFF_DLY && q.ph < toffd_ms // R13
                                 |=> q.st != S_FALL)
    else $error("fall began before turn-off delay");
  fall_min_a: assert property (q.st == S_FALL && q.ph < 18'h0000A && !uv_trip // R14
                               |=> q.st == S_FALL)
    else $error("fall shorter than 10 ms");
  toff_warn_a: assert property ($rose(q.toff_wrn) |-> !fault_alert_pin_n ##1 q.toff_wrn) // R15
    else $error("fall overrun did not hold the alert low");
  status_bits_a: assert property (1'b1 |=> q.status[5:1] == $past({vout_ov_fault, // R16
                                  iout_oc_fault, vin_uv_fault, temp_fault, cml_fault}))
    else $error("status byte does not follow the fault inputs");
endmodule // power_seq_monitor

// File: verilog/power_seq_pkg.sv
// Types shared by the power sequencer modules.
// Assumes the timing counters of the sequencer are 18 bits wide.
package power_seq_pkg;
  typedef enum logic [2:0] {S_OFF, S_TON_DLY, S_RISE, S_ON, S_TOFF_DLY, S_FALL} seq_state_t;

  typedef struct packed {
    seq_state_t       st;
    logic [7:0]       uv_resp;
    logic [15:0]      pg_on_lvl;
    logic [15:0]      pg_off_lvl;
    logic [5:0][15:0] tim;
    logic [17:0]      ph;
    logic [17:0]      on_cnt;
    logic [17:0]      off_cnt;
    logic             on_run;
    logic             off_run;
    logic             latched;
    logic             ton_flt;
    logic             toff_wrn;
    logic             por_pend;
    logic             ctrl_prev;
    logic             op_prev;
    logic             vin_prev;
    logic             out_en;
    logic             rise;
    logic             fall;
    logic             pg;
    logic             alert_n;
    logic [7:0]       status;
    logic [15:0]      rdata;
  } seq_regs_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_regs_t;
endpackage
